// File: hw/brl_cfg.svh
`ifndef BRL_CFG_SVH
`define BRL_CFG_SVH

`define BRL_ADDR_W          8
`define BRL_DATA_W          8
`define BRL_ADDR_BIASCFG    8'h03
`define BRL_ADDR_LEAD_OFF_CONTROL       8'h04
`define BRL_ADDR_IRQ_STAT   8'h10
`define BRL_ADDR_IRQ_MASK   8'h11
`define BRL_RST_BIASCFG     8'h60
`define BRL_RST_LEAD_OFF_CONTROL        8'h00
`define BRL_RST_MASK        8'h00
`define BRL_BIT_REFBUF      7
`define BRL_BIT_RSV_HI      6
`define BRL_BIT_RSV_LO      5
`define BRL_BIT_MEAS        4
`define BRL_BIT_REFINT      3
`define BRL_BIT_BIASBUF     2
`define BRL_BIT_SENSE       1
`define BRL_BIT_STAT        0
`define BRL_LEAD_OFF_CONTROL_TH_HI      7
`define BRL_LEAD_OFF_CONTROL_TH_LO      5
`define BRL_LEAD_OFF_CONTROL_RSV        4
`define BRL_LEAD_OFF_CONTROL_IMAG_HI    3
`define BRL_LEAD_OFF_CONTROL_IMAG_LO    2
`define BRL_LEAD_OFF_CONTROL_FREQ_HI    1
`define BRL_LEAD_OFF_CONTROL_FREQ_LO    0
`define BRL_MUX_BIAS_MEASURE_ROUTE   3'h2
`define BRL_IRQ_BIT_OPEN    0
`define BRL_IRQ_BIT_CLOSE   1
`define BRL_IRQ_W           2

`endif

// File: hw/brl_pkg.sv
`include "brl_cfg.svh"
package brl_pkg;
    typedef logic [`BRL_ADDR_W-1:0] brl_addr_t;
    typedef logic [`BRL_DATA_W-1:0] brl_data_t;
    typedef logic [2:0]             brl_mux_t;
endpackage

// File: hw/brl_regs.sv
// Overview of operation
// - Bit 7 of the bias config register powers the reference buffer: 0 off, 1 on, reset 0.
// - Bias measure bit 4, when 1, routes the bias input to each channel selecting input code 010.
// - Bias measurement routing is available on any channel, not a fixed one.
// - Bit 3 picks the bias reference: 0 external feed, 1 internal mid-supply.
// - Bit 2 powers the bias buffer: 0 off, 1 on, reset 0.
// - Bit 1 enables the bias sense function when 1.
// - Read-only bit 0 shows bias open (1) or connected (0); writes do not change it.
// - The lead-off control register sits at 04h and resets to 00h.
// - Lead-off fields: threshold 7:5, current 3:2, frequency 1:0, bit 4 held zero.
// - The bias config register sits at 03h and resets to 60h.
`include "brl_cfg.svh"
module brl_regs #(
    parameter int CHANNELS = 8
) (
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire brl_pkg::brl_addr_t       addr_i,
    input  wire brl_pkg::brl_data_t       wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output brl_pkg::brl_data_t            rdata_o,
    input  wire logic                     bias_open_i,
    input  wire logic [3*CHANNELS-1:0]    channel_input_select_i,
    output logic                          ref_buffer_power_on_o,
    output logic                          bias_reference_internal_select_o,
    output logic                          bias_buffer_power_on_o,
    output logic                          bias_sense_enable_o,
    output logic [CHANNELS-1:0]           bias_measure_route_o,
    output logic [2:0]                    leadoff_comparator_threshold_o,
    output logic [1:0]                    leadoff_current_magnitude_o,
    output logic [1:0]                    leadoff_frequency_select_o,
    output logic                          irq_o
);
    import brl_pkg::*;

    brl_data_t              bias_cfg_reg, bias_cfg_next;
    brl_data_t              lead_off_control_reg,     lead_off_control_next;
    logic [`BRL_IRQ_W-1:0]  stat_reg,     stat_next;
    logic [`BRL_IRQ_W-1:0]  mask_reg,     mask_next;
    brl_data_t              rdata_reg,    rdata_next;
    logic                   open_d_reg;
    logic [CHANNELS-1:0]    route_reg,    route_next;
    logic                   irq_reg,      irq_next;
    logic                   refbuf_reg,   refint_reg, biasbuf_reg, sense_reg;
    logic                   open_s;

    // Lead-off comparator output is asynchronous to this clock
    brl_sync u_open_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    (bias_open_i),
        .q_o    (open_s)
    );

    function automatic logic is_bias_measure_route(input brl_mux_t sel);
        return sel == `BRL_MUX_BIAS_MEASURE_ROUTE;
    endfunction

    always_comb begin
        bias_cfg_next = bias_cfg_reg;
        lead_off_control_next     = lead_off_control_reg;
        mask_next     = mask_reg;
        stat_next     = stat_reg;
        rdata_next    = 8'h00;
        if (wr_i) begin
            unique case (addr_i)
                `BRL_ADDR_BIASCFG: begin
                    // Status bit is never stored from the bus
                    bias_cfg_next = {wdata_i[7:1], 1'b0};
                end
                `BRL_ADDR_LEAD_OFF_CONTROL: begin
                    lead_off_control_next = wdata_i & ~(8'h01 << `BRL_LEAD_OFF_CONTROL_RSV);
                end
                `BRL_ADDR_IRQ_MASK: begin
                    mask_next = wdata_i[`BRL_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                `BRL_ADDR_BIASCFG: rdata_next = {bias_cfg_reg[7:1], open_s};
                `BRL_ADDR_LEAD_OFF_CONTROL:    rdata_next = lead_off_control_reg;
                `BRL_ADDR_IRQ_STAT: begin
                    rdata_next = {6'h00, stat_reg};
                    stat_next  = '0;
                end
                `BRL_ADDR_IRQ_MASK: rdata_next = {6'h00, mask_reg};
                default:           rdata_next = 8'h00;
            endcase
        end
        // New events win over the read-clear in the same cycle
        if (open_s && !open_d_reg) begin
            stat_next[`BRL_IRQ_BIT_OPEN] = 1'b1;
        end
        if (!open_s && open_d_reg) begin
            stat_next[`BRL_IRQ_BIT_CLOSE] = 1'b1;
        end
        irq_next = |(stat_next & mask_next);
    end

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            // Every channel is eligible, selection is purely by its input code
            route_next[c] = bias_cfg_next[`BRL_BIT_MEAS] &
                            is_bias_measure_route(channel_input_select_i[3*c +: 3]);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bias_cfg_reg <= `BRL_RST_BIASCFG;
            lead_off_control_reg     <= `BRL_RST_LEAD_OFF_CONTROL;
            mask_reg     <= '0;
            stat_reg     <= '0;
            rdata_reg    <= 8'h00;
            open_d_reg   <= 1'b0;
            route_reg    <= '0;
            irq_reg      <= 1'b0;
            refbuf_reg   <= 1'b0;
            refint_reg   <= 1'b0;
            biasbuf_reg  <= 1'b0;
            sense_reg    <= 1'b0;
        end else begin
            bias_cfg_reg <= bias_cfg_next;
            lead_off_control_reg     <= lead_off_control_next;
            mask_reg     <= mask_next;
            stat_reg     <= stat_next;
            rdata_reg    <= rdata_next;
            open_d_reg   <= open_s;
            route_reg    <= route_next;
            irq_reg      <= irq_next;
            refbuf_reg   <= bias_cfg_next[`BRL_BIT_REFBUF];
            refint_reg   <= bias_cfg_next[`BRL_BIT_REFINT];
            biasbuf_reg  <= bias_cfg_next[`BRL_BIT_BIASBUF];
            sense_reg    <= bias_cfg_next[`BRL_BIT_SENSE];
        end
    end

    // Reserved bits 6:5 are stored as written; host is expected to keep them set
    assign rdata_o                          = rdata_reg;
    assign ref_buffer_power_on_o            = refbuf_reg;
    assign bias_reference_internal_select_o = refint_reg;
    assign bias_buffer_power_on_o           = biasbuf_reg;
    assign bias_sense_enable_o              = sense_reg;
    assign bias_measure_route_o             = route_reg;
    assign leadoff_comparator_threshold_o   = lead_off_control_reg[`BRL_LEAD_OFF_CONTROL_TH_HI:`BRL_LEAD_OFF_CONTROL_TH_LO];
    assign leadoff_current_magnitude_o      = lead_off_control_reg[`BRL_LEAD_OFF_CONTROL_IMAG_HI:`BRL_LEAD_OFF_CONTROL_IMAG_LO];
    assign leadoff_frequency_select_o       = lead_off_control_reg[`BRL_LEAD_OFF_CONTROL_FREQ_HI:`BRL_LEAD_OFF_CONTROL_FREQ_LO];
    assign irq_o                            = irq_reg;
endmodule

// File: hw/brl_sync.sv
module brl_sync (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;
    logic q_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= 1'b0;
            q_reg    <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule

// File: tb/brl_bias_electrode.sv
module brl_bias_electrode (
    input  wire logic detach_i,
    output logic      bias_open_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Lead state moves off the clock edge, as a real electrode would
    // One process owns the pin so it has a single driver from time zero
    initial begin
        bias_open_o = 1'b0;
        forever begin
            @(detach_i);
            bias_open_o <= #13 detach_i;
        end
    end
endmodule

// File: tb/brl_regs_bench.sv
module brl_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import brl_pkg::*;
    logic              clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, detach = 0;
    brl_addr_t         addr_i = 8'h00;
    brl_data_t         wdata_i = 8'h00, rdata_o;
    logic [23:0]       channel_input_select_i = 24'h44924a;
    logic              bias_open_i, ref_buffer_power_on_o, bias_reference_internal_select_o;
    logic              bias_buffer_power_on_o, bias_sense_enable_o, irq_o;
    logic [7:0]        bias_measure_route_o;
    logic [2:0]        leadoff_comparator_threshold_o;
    logic [1:0]        leadoff_current_magnitude_o, leadoff_frequency_select_o;
    int                mismatches = 0, n_compared = 0, cycles = 0;
    brl_regs uut (.*);
    brl_bias_electrode model (.detach_i(detach), .bias_open_o(bias_open_i));
    initial forever #50 clk_i = ~clk_i;
    task complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        // Whole sequence needs well under a hundred cycles
        if (cycles == 2000) begin mismatches++; complete_run(); end
    end
    task chk(input brl_data_t got, input brl_data_t exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input brl_addr_t a, input brl_data_t d);
        @(posedge clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
        @(posedge clk_i); wr_i <= 0;
    endtask
    task rd(input brl_addr_t a, input brl_data_t e);
        @(posedge clk_i); addr_i <= a; rd_i <= 1;
        @(posedge clk_i); rd_i <= 0;
        @(negedge clk_i); chk(rdata_o, e);
    endtask
    function automatic brl_data_t ctl();
        return {4'h0, ref_buffer_power_on_o, bias_reference_internal_select_o,
                bias_buffer_power_on_o, bias_sense_enable_o};
    endfunction
    task t_reset();
        rd(8'h03, 8'h60);
        rd(8'h04, 8'h00);
        rd(8'h20, 8'h00);
        chk(ctl(), 8'h00);
        $display("test reset done");
    endtask
    task t_lead_off_control();
        wr(8'h04, 8'h5a);
        rd(8'h04, 8'h4a);
        chk({1'b0, leadoff_comparator_threshold_o, leadoff_current_magnitude_o,
             leadoff_frequency_select_o}, 8'h2a);
        $display("test lead-off done");
    endtask
    task t_cfg();
        wr(8'h03, 8'he6);
        @(negedge clk_i); chk(ctl(), 8'h0b);
        wr(8'h03, 8'h69);
        @(negedge clk_i); chk(ctl(), 8'h04);
        rd(8'h03, 8'h68);
        $display("test config done");
    endtask
    task t_route();
        wr(8'h03, 8'h70);
        @(negedge clk_i); chk(bias_measure_route_o, 8'h81);
        // Move the bias code to a middle channel; routing follows the live select
        @(posedge clk_i) channel_input_select_i <= 24'h000400;
        @(posedge clk_i);
        @(negedge clk_i); chk(bias_measure_route_o, 8'h08);
        wr(8'h03, 8'h60);
        @(negedge clk_i); chk(bias_measure_route_o, 8'h00);
        $display("test route done");
    endtask
    task t_irq();
        wr(8'h11, 8'h01);
        detach <= 1;
        repeat (5) @(negedge clk_i); chk({7'h0, irq_o}, 8'h01);
        rd(8'h03, 8'h61);
        rd(8'h10, 8'h01);
        repeat (2) @(negedge clk_i); chk({7'h0, irq_o}, 8'h00);
        detach <= 0;
        // Closing event is masked, so the output must stay low
        repeat (5) @(negedge clk_i); chk({7'h0, irq_o}, 8'h00);
        rd(8'h10, 8'h02);
        rd(8'h11, 8'h01);
        $display("test interrupt done");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1;
        t_reset();
        t_lead_off_control();
        t_cfg();
        t_route();
        t_irq();
        complete_run();
    end
endmodule

// File: tb/brl_regs_checker.sv
module brl_regs_checker #(parameter int CHANNELS = 8) (
    input wire logic                  clk_i,
    input wire logic                  rstn_i,
    input wire brl_pkg::brl_addr_t    addr_i,
    input wire brl_pkg::brl_data_t    wdata_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire brl_pkg::brl_data_t    rdata_o,
    input wire logic [3*CHANNELS-1:0] channel_input_select_i,
    input wire logic                  ref_buffer_power_on_o,
    input wire logic                  bias_reference_internal_select_o,
    input wire logic                  bias_buffer_power_on_o,
    input wire logic                  bias_sense_enable_o,
    input wire logic [CHANNELS-1:0]   bias_measure_route_o,
    input wire logic [2:0]            leadoff_comparator_threshold_o,
    input wire logic [1:0]            leadoff_current_magnitude_o,
    input wire logic [1:0]            leadoff_frequency_select_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cfg_wr;
    logic lead_off_control_wr;
    assign cfg_wr = wr_i && addr_i == 8'h03;
    assign lead_off_control_wr = wr_i && addr_i == 8'h04;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    a_refbuf_write: assert property (cfg_wr |=> ref_buffer_power_on_o == $past(wdata_i[7]))
        else $error("reference buffer wrong");
    a_refint_write: assert property (cfg_wr |=> bias_reference_internal_select_o == $past(wdata_i[3]))
        else $error("reference select wrong");
    a_biasbuf_write: assert property (cfg_wr |=> bias_buffer_power_on_o == $past(wdata_i[2]))
        else $error("bias buffer wrong");
    a_sense_write: assert property (cfg_wr |=> bias_sense_enable_o == $past(wdata_i[1]))
        else $error("sense enable wrong");
    a_lead_off_control_fields: assert property (lead_off_control_wr |=> {leadoff_comparator_threshold_o,
        leadoff_current_magnitude_o, leadoff_frequency_select_o} ==
        {$past(wdata_i[7:5]), $past(wdata_i[3:0])}) else $error("lead-off fields wrong");
    a_route_first: assert property (cfg_wr |=> bias_measure_route_o[0] ==
        ($past(wdata_i[4]) && $past(channel_input_select_i[2:0]) == 3'h2))
        else $error("first channel route wrong");
    a_route_last: assert property (cfg_wr |=> bias_measure_route_o[CHANNELS-1] ==
        ($past(wdata_i[4]) && $past(channel_input_select_i[3*CHANNELS-1 -: 3]) == 3'h2))
        else $error("last channel route wrong");
    c_cfg_write: cover property (cfg_wr);
    c_lead_off_control_write: cover property (lead_off_control_wr);
    c_status_read: cover property (rd_i && addr_i == 8'h10);
endmodule
bind brl_regs brl_regs_checker #(.CHANNELS(CHANNELS)) chk (.*);
